// >>> src/adc_seq_pkg.sv
// shared constants and types for the converter sequencer
package adc_seq_pkg;

  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned RESULT_W     = 10;
  localparam int unsigned CHAN_W       = 5;
  localparam int unsigned CLKSEL_W     = 3;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned DIV_W        = 7;
  localparam int unsigned HALF_TAD_CNT = 23; // 11.5 periods as half periods
  localparam int unsigned HALF_W       = 5;
  localparam int unsigned BIT_W        = 4;

  // register offsets
  localparam logic [3:0] OFS_CTRL0   = 4'h0;
  localparam logic [3:0] OFS_CTRL1   = 4'h1;
  localparam logic [3:0] OFS_RES_HI  = 4'h2;
  localparam logic [3:0] OFS_RES_LO  = 4'h3;
  localparam logic [3:0] OFS_FLAG    = 4'h4;
  localparam logic [3:0] OFS_ENABLE  = 4'h5;

  // control zero fields
  localparam int unsigned CTRL0_ON_BIT  = 0;
  localparam int unsigned CTRL0_GO_BIT  = 1;
  localparam int unsigned CTRL0_CHS_LSB = 2;
  // control one fields
  localparam int unsigned CTRL1_PREF_BIT = 0;
  localparam int unsigned CTRL1_CS_LSB   = 4;
  localparam int unsigned CTRL1_FM_BIT   = 7;
  // flag / enable registers
  localparam int unsigned FLAG_DONE_BIT  = 6;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] RESULT_ZERO = 10'h000;
  localparam logic [4:0] CHAN_LAST  = 5'h1f;

  // clock select encodings
  localparam logic [2:0] CS_DIV2  = 3'h0;
  localparam logic [2:0] CS_DIV4  = 3'h4;
  localparam logic [2:0] CS_DIV8  = 3'h1;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  localparam logic [1:0] CS_RC_LOW = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV  = 2'b10
  } conv_state_t;

endpackage : adc_seq_pkg

// >>> src/tad_clock_gen.sv
// half-period tick generator for the bit conversion period
`timescale 1ns/1ps
`default_nettype none
module tad_clock_gen
  import adc_seq_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                run,
  input  wire logic [CLKSEL_W-1:0] clk_sel,
  input  wire logic                rc_tick,
  output logic                     half_tick
);

  function automatic logic [DIV_W-1:0] half_div(input logic [CLKSEL_W-1:0] s);
    case (s)
      CS_DIV2:  half_div = 7'h01;
      CS_DIV4:  half_div = 7'h02;
      CS_DIV8:  half_div = 7'h04;
      CS_DIV16: half_div = 7'h08;
      CS_DIV32: half_div = 7'h10;
      CS_DIV64: half_div = 7'h20;
      default:  half_div = 7'h01;
    endcase
  endfunction : half_div

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  wire              use_rc = (clk_sel[1:0] == CS_RC_LOW);
  wire              wrap   = (cnt_q + 7'h01 >= half_div(clk_sel));

  assign cnt_d     = (!run || wrap) ? 7'h00 : cnt_q + 7'h01;
  assign half_tick = run && (use_rc ? rc_tick : wrap);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) cnt_q <= 7'h00;
    else        cnt_q <= use_rc ? 7'h00 : cnt_d;
  end

endmodule : tad_clock_gen
`default_nettype wire

// >>> src/sar_core.sv
// successive approximation register with partial-result fill
`timescale 1ns/1ps
`default_nettype none
module sar_core
  import adc_seq_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                start,
  input  wire logic                step,
  input  wire logic                comp_hi,
  output logic [RESULT_W-1:0]      trial,
  output logic [RESULT_W-1:0]      partial
);

  logic [RESULT_W-1:0] sar_q;
  logic [RESULT_W-1:0] mask_q;
  logic                last_q;
  logic [RESULT_W-1:0] decided;

  assign trial = sar_q | mask_q;

  // unconverted bits copy the last decided bit
  always_comb begin
    decided = sar_q;
    for (int i = 0; i < RESULT_W; i++) begin
      if (((mask_q >> i) != '0) || mask_q == '0 && 1'b0) decided[i] = last_q;
    end
    for (int i = 0; i < RESULT_W; i++) begin
      if ((mask_q >> i) == '0) decided[i] = sar_q[i];
    end
  end
  assign partial = decided;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || start) begin
      sar_q  <= RESULT_ZERO;
      mask_q <= {1'b1, {(RESULT_W-1){1'b0}}};
      last_q <= 1'b0;
    end else if (step && mask_q != '0) begin
      sar_q  <= comp_hi ? (sar_q | mask_q) : sar_q;
      last_q <= comp_hi;
      mask_q <= mask_q >> 1;
    end
  end

endmodule : sar_core
`default_nettype wire

// >>> src/sar_adc_sequencer.sv
// converter control: registers, start/stop sequencing, result formatting
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [DATA_W-1:0]        reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [DATA_W-1:0]             reg_rdata,
  input  wire logic                     sleep_active,
  input  wire logic                     instr_tick,
  input  wire logic                     rc_tick,
  input  wire logic                     special_event,
  input  wire logic                     comp_hi,
  output logic [CHAN_W-1:0]             channel_select_field,
  output logic                          positive_reference_select,
  output logic                          analog_power,
  output logic                          sample_hold,
  output logic [RESULT_W-1:0]           dac_trial,
  output logic                          timer_clear,
  output logic                          conversion_irq,
  output logic                          wake_request
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [CHAN_W-1:0]   chs_q;
  logic                on_q;
  logic                go_q;
  logic                pref_q;
  logic [CLKSEL_W-1:0] cs_q;
  logic                fm_q;
  logic                flag_q;
  logic                ien_q;
  logic [RESULT_W-1:0] result_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                pd_q;
  logic                tclr_q;

  conv_state_t         state_q;
  conv_state_t         state_d;
  logic [HALF_W-1:0]   half_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire wr_ctrl0 = reg_wr && (reg_addr == OFS_CTRL0);
  wire wr_ctrl1 = reg_wr && (reg_addr == OFS_CTRL1);
  wire wr_flag  = reg_wr && (reg_addr == OFS_FLAG);
  wire wr_en    = reg_wr && (reg_addr == OFS_ENABLE);

  wire rc_sel     = (cs_q[1:0] == CS_RC_LOW);
  wire sw_go      = wr_ctrl0 && reg_wdata[CTRL0_GO_BIT];
  wire sw_stop    = wr_ctrl0 && !reg_wdata[CTRL0_GO_BIT];
  wire start_req  = on_q && !go_q && (sw_go || special_event);
  wire busy       = (state_q != ST_IDLE);
  wire sleep_kill = busy && sleep_active && !rc_sel;
  wire abort      = busy && (sw_stop || !on_q || sleep_kill);
  wire in_conv    = (state_q == ST_CONV);

  logic half_tick;
  logic [RESULT_W-1:0] partial;

  wire finish    = in_conv && half_tick && (half_q == HALF_W'(HALF_TAD_CNT - 1));
  wire bit_step  = in_conv && half_tick && half_q[0] && (half_q > 5'h01);
  wire load_res  = finish || abort;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  tad_clock_gen u_tad (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .run       (in_conv),
    .clk_sel   (cs_q),
    .rc_tick   (rc_tick),
    .half_tick (half_tick)
  );

  sar_core u_sar (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (start_req),
    .step    (bit_step),
    .comp_hi (comp_hi),
    .trial   (dac_trial),
    .partial (partial)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (start_req) state_d = rc_sel ? ST_DELAY : ST_CONV;
      ST_DELAY: if (instr_tick) state_d = ST_CONV;
      ST_CONV:  if (finish) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
    if (abort) state_d = ST_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      half_q  <= '0;
    end else begin
      state_q <= state_d;
      half_q  <= (!in_conv) ? '0 : (half_tick ? half_q + 5'h01 : half_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chs_q  <= '0;
      on_q   <= 1'b0;
      pref_q <= 1'b0;
      cs_q   <= '0;
      fm_q   <= 1'b0;
      ien_q  <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        chs_q <= reg_wdata[CTRL0_CHS_LSB +: CHAN_W];
        on_q  <= reg_wdata[CTRL0_ON_BIT];
      end
      if (wr_ctrl1) begin
        pref_q <= reg_wdata[CTRL1_PREF_BIT];
        cs_q   <= reg_wdata[CTRL1_CS_LSB +: CLKSEL_W];
        fm_q   <= reg_wdata[CTRL1_FM_BIT];
      end
      if (wr_en) ien_q <= reg_wdata[FLAG_DONE_BIT];
    end
  end

  // go bit: set on start, cleared by completion or abort
  always_ff @(posedge clk_sys) begin
    if (!rst_n)          go_q <= 1'b0;
    else if (start_req)  go_q <= 1'b1;
    else if (load_res)   go_q <= 1'b0;
  end

  // flag: hardware set beats software clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n)       flag_q <= 1'b0;
    else if (finish)  flag_q <= 1'b1;
    else if (wr_flag) flag_q <= reg_wdata[FLAG_DONE_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)         result_q <= RESULT_ZERO;
    else if (finish)    result_q <= dac_trial & partial | partial;
    else if (abort)     result_q <= partial;
  end

  // power-down while on bit remains set
  always_ff @(posedge clk_sys) begin
    if (!rst_n)                               pd_q <= 1'b0;
    else if (start_req || !sleep_active)      pd_q <= 1'b0;
    else if (sleep_kill)                      pd_q <= 1'b1;
    else if (finish && !ien_q)                pd_q <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) tclr_q <= 1'b0;
    else        tclr_q <= special_event && on_q && !go_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  function automatic logic [2*DATA_W-1:0] justify(input logic [RESULT_W-1:0] r,
                                                  input logic fm);
    justify = fm ? {6'h00, r} : {r, 6'h00};
  endfunction : justify

  wire [2*DATA_W-1:0] res_pair = justify(result_q, fm_q);
  logic [DATA_W-1:0]  rd_mux;

  always_comb begin
    rd_mux = RESET_BYTE;
    case (reg_addr)
      OFS_CTRL0:  rd_mux = {1'b0, chs_q, go_q, on_q};
      OFS_CTRL1:  rd_mux = {fm_q, cs_q, 3'h0, pref_q};
      OFS_RES_HI: rd_mux = res_pair[2*DATA_W-1:DATA_W];
      OFS_RES_LO: rd_mux = res_pair[DATA_W-1:0];
      OFS_FLAG:   rd_mux = {1'b0, flag_q, 6'h00};
      OFS_ENABLE: rd_mux = {1'b0, ien_q, 6'h00};
      default:    rd_mux = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)      rdata_q <= RESET_BYTE;
    else if (reg_rd) rdata_q <= rd_mux;
    else             rdata_q <= RESET_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata                 = rdata_q;
  assign channel_select_field      = chs_q;
  assign positive_reference_select = pref_q;
  assign analog_power              = on_q && !pd_q;
  assign sample_hold               = busy;
  assign timer_clear               = tclr_q;
  assign conversion_irq            = flag_q && ien_q;
  assign wake_request              = conversion_irq && sleep_active;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    finish |=> flag_q)
    else $error("done flag not set after completion");

  go_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && !start_req) |=> !go_q)
    else $error("go not cleared at completion");

  go_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start_req |=> go_q && busy)
    else $error("go not set at start");

  irq_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    conversion_irq == (flag_q && ien_q))
    else $error("interrupt request mismatch");

  rc_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (start_req && rc_sel && !abort) |=> state_q == ST_DELAY)
    else $error("rc start did not wait");

  sleep_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sleep_kill |=> !busy && !analog_power && on_q)
    else $error("sleep did not abort");

  off_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !on_q && !start_req |=> !busy)
    else $error("conversion ran while off");

  flag_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flag_q && !wr_flag |=> flag_q)
    else $error("flag cleared by hardware");

  just_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fm_q |-> res_pair[2*DATA_W-1:RESULT_W] == '0)
    else $error("unused result bits not zero");

  abort_res_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    abort |=> result_q == $past(partial))
    else $error("partial result not stored");

  timer_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    timer_clear |=> !timer_clear)
    else $error("timer clear longer than one cycle");

  event_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (special_event && on_q && !go_q) |=> go_q && timer_clear)
    else $error("special event did not start");

  result_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    finish |=> result_q == $past(partial))
    else $error("result not loaded at completion");

  wake_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && ien_q && !wr_en && sleep_active) |=> wake_request || !sleep_active)
    else $error("completion did not wake");

  sleep_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && !ien_q && sleep_active) |=> !analog_power && on_q)
    else $error("converter not powered down");

  off_power_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !on_q |-> !analog_power)
    else $error("power on while converter off");

  reset_idle_a: assert property (@(posedge clk_sys)
    !rst_n |=> !busy && !go_q && !on_q)
    else $error("reset did not stop converter");

  chan_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_ctrl0 |=> channel_select_field == $past(reg_wdata[CTRL0_CHS_LSB +: CHAN_W]))
    else $error("channel select not taken");

  finish_c: cover property (@(posedge clk_sys) disable iff (!rst_n) finish);
  abort_c:  cover property (@(posedge clk_sys) disable iff (!rst_n) abort && sw_stop);
  event_c:  cover property (@(posedge clk_sys) disable iff (!rst_n)
    special_event && start_req);
  sleep_c:  cover property (@(posedge clk_sys) disable iff (!rst_n) sleep_kill);

endmodule : sar_adc_sequencer
`default_nettype wire

// >>> bench/afe_model.sv
// analog front end model: channel mux, sample-hold and comparator
`timescale 1ns/1ps
`default_nettype none
module afe_model (
  input  wire logic                            clk_sys,
  input  wire logic [adc_seq_pkg::CHAN_W-1:0]   channel_select_field,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0] dac_trial,
  input  wire logic                            sample_hold,
  output logic                                 comp_hi
);
  import adc_seq_pkg::*;
  logic [RESULT_W-1:0] level;
  logic                junk_q = 1'b0;
  // each source has its own level
  assign level = {channel_select_field, ~channel_select_field};
  always @(posedge clk_sys) begin
    junk_q <= ~junk_q;
  end
  // level sits half a step above its code, so no trial ties; noise outside hold
  assign comp_hi = sample_hold ? ({level, 1'b1} > {dac_trial, 1'b0}) : junk_q;
endmodule : afe_model
`default_nettype wire

// >>> bench/tb_sar_adc_sequencer.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_sequencer;
  import adc_seq_pkg::*;
  typedef struct {
    logic [4:0] ch;
    logic [2:0] cs;
    logic       fm;
    logic       pref;
    int         lo;
    int         hi;
  } row_t;
  logic                clk_sys = 1'b0;
  logic                rst_n = 1'b0;
  logic [ADDR_W-1:0]   reg_addr = '0;
  logic [DATA_W-1:0]   reg_wdata = '0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [DATA_W-1:0]   reg_rdata;
  logic                sleep_active = 1'b0;
  logic                instr_tick = 1'b0;
  logic                rc_tick = 1'b0;
  logic                special_event = 1'b0;
  logic                comp_hi;
  logic [CHAN_W-1:0]   channel_select_field;
  logic                positive_reference_select;
  logic                analog_power;
  logic                sample_hold;
  logic [RESULT_W-1:0] dac_trial;
  logic                timer_clear;
  logic                conversion_irq;
  logic                wake_request;
  int                  num_errors = 0;
  int                  checks = 0;
  int                  tk = 0;
  int                  busy_cnt = 0;
  int                  busy_len = 0;
  logic [7:0]          rd_q;
  logic [7:0]          hi_q;
  logic [9:0]          v;
  logic                hit;
  row_t rows [8] = '{
    '{5'h00, CS_DIV2, 1'b1, 1'b0, 23, 26}, '{5'h1f, CS_DIV4, 1'b0, 1'b1, 46, 49},
    '{5'h0a, CS_DIV8, 1'b1, 1'b1, 92, 95}, '{5'h15, CS_DIV16, 1'b0, 1'b0, 184, 187},
    '{5'h03, CS_DIV32, 1'b1, 1'b0, 368, 371}, '{5'h1c, CS_DIV64, 1'b0, 1'b1, 736, 739},
    '{5'h11, 3'h3, 1'b1, 1'b0, 66, 80}, '{5'h0e, 3'h7, 1'b1, 1'b1, 66, 80}};

  sar_adc_sequencer dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sleep_active, .instr_tick, .rc_tick, .special_event, .comp_hi,
    .channel_select_field, .positive_reference_select, .analog_power, .sample_hold,
    .dac_trial, .timer_clear, .conversion_irq, .wake_request);
  afe_model afe (.clk_sys, .channel_select_field, .dac_trial, .sample_hold, .comp_hi);

  ////////////////////////////////////////////////////////////////////////////////
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tk <= tk + 1;
    instr_tick <= (tk % 4 == 0);
    rc_tick <= (tk % 3 == 0);
    if (sample_hold === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end else if (busy_cnt != 0) begin
      busy_len <= busy_cnt;
      busy_cnt <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask : rd
  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while (sample_hold !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 2000, 1'b1);
    repeat (2) @(posedge clk_sys);
  endtask : wait_idle
  task automatic rd_pair();
    rd(OFS_RES_HI);
    hi_q = rd_q;
    rd(OFS_RES_LO);
  endtask : rd_pair
  function automatic logic [15:0] fmt(input logic [9:0] x, input logic fm);
    return fm ? {6'h00, x} : {x, 6'h00};
  endfunction : fmt
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #3_000_000;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_CTRL0);
    chk(rd_q, RESET_BYTE);
    rd(4'hf);
    chk(rd_q, 8'h00);
    wr(OFS_CTRL0, 8'h02);
    #1 chk(sample_hold, 1'b0);
    foreach (rows[i]) begin
      v = {rows[i].ch, ~rows[i].ch};
      wr(OFS_CTRL1, {rows[i].fm, rows[i].cs, 3'b000, rows[i].pref});
      wr(OFS_CTRL0, {1'b0, rows[i].ch, 2'b01});
      repeat (4) @(posedge clk_sys);
      chk({channel_select_field, positive_reference_select}, {rows[i].ch, rows[i].pref});
      wr(OFS_CTRL0, {1'b0, rows[i].ch, 2'b11});
      rd(OFS_CTRL0);
      chk(rd_q[CTRL0_GO_BIT], 1'b1);
      wait_idle();
      chk(busy_len >= rows[i].lo && busy_len <= rows[i].hi, 1'b1);
      rd(OFS_CTRL0);
      chk(rd_q, {1'b0, rows[i].ch, 2'b01});
      rd(OFS_FLAG);
      chk(rd_q[FLAG_DONE_BIT], 1'b1);
      rd_pair();
      chk({hi_q, rd_q}, fmt(v, rows[i].fm));
      wr(OFS_FLAG, 8'h00);
    end
    rd(OFS_FLAG);
    chk(rd_q, 8'h00);
    // completion in sleep, interrupt on, then off
    wr(OFS_ENABLE, 8'h40);
    wr(OFS_CTRL0, 8'h3b);
    sleep_active <= 1'b1;
    wait_idle();
    chk({wake_request, conversion_irq}, 2'b11);
    sleep_active <= 1'b0;
    wr(OFS_FLAG, 8'h00);
    @(posedge clk_sys);
    #1 chk(conversion_irq, 1'b0);
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_CTRL0, 8'h3b);
    sleep_active <= 1'b1;
    wait_idle();
    chk(analog_power, 1'b0);
    rd(OFS_CTRL0);
    chk(rd_q, 8'h39);
    sleep_active <= 1'b0;
    // sleep with a system-clock divider aborts
    wr(OFS_CTRL1, {1'b1, CS_DIV64, 4'h0});
    wr(OFS_CTRL0, 8'h3b);
    repeat (20) @(posedge clk_sys);
    sleep_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk({sample_hold, analog_power}, 2'b00);
    rd(OFS_CTRL0);
    chk(rd_q, 8'h39);
    sleep_active <= 1'b0;
    // software abort keeps partial result, undecided bits copy the last one
    v = {5'h0e, 5'h11};
    wr(OFS_CTRL0, 8'h3b);
    repeat (300) @(posedge clk_sys);
    wr(OFS_CTRL0, 8'h39);
    wait_idle();
    rd_pair();
    hit = 1'b0;
    for (int k = 1; k <= 10; k++) begin
      if ({hi_q, rd_q} === {6'h00, v >> (10 - k) << (10 - k) | {10{v[10 - k]}} >> k}) hit = 1'b1;
    end
    chk(hit, 1'b1);
    // compare special event start, timing left to the stimulus
    wr(OFS_CTRL1, {1'b1, CS_DIV2, 4'h0});
    wr(OFS_FLAG, 8'h00);
    special_event <= 1'b1;
    @(posedge clk_sys);
    special_event <= 1'b0;
    hit = 1'b0;
    repeat (3) begin
      #1 if (timer_clear === 1'b1) hit = 1'b1;
      @(posedge clk_sys);
    end
    chk(hit, 1'b1);
    #1 chk(sample_hold, 1'b1);
    wait_idle();
    rd_pair();
    chk({hi_q, rd_q}, fmt(v, 1'b1));
    // reset in mid-conversion
    wr(OFS_CTRL1, {1'b1, CS_DIV64, 4'h0});
    wr(OFS_CTRL0, 8'h3b);
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({sample_hold, analog_power}, 2'b00);
    rd(OFS_CTRL0);
    chk(rd_q, RESET_BYTE);
    rd(OFS_CTRL1);
    chk(rd_q, RESET_BYTE);
    complete_run();
  end
endmodule : tb_sar_adc_sequencer
`default_nettype wire
